/* dv/test_conditional_branch_unit.sv */
// Self-checking bench for the conditional branch unit.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); n_fail++; end end
module test_conditional_branch_unit;
   logic clk;
   logic rst_b;
   logic instr_valid;
   cbu_pkg::cbu_instr_t instr;
   logic source_mode;
   logic [15:0] pc_in;
   cbu_pkg::cbu_flags_t flags;
   logic [7:0] acc;
   logic [15:0] data_pointer;
   logic bit_value;
   logic pc_valid_q;
   logic [15:0] pc_q;
   logic branch_taken_q;
   logic handled_q;
   int n_fail;
   int n_tests;
   int n_cycles;
   logic [15:0] last_pc;
   logic [7:0] ops [0:11] = '{8'h38, 8'h28, 8'h78, 8'h18, 8'h58, 8'h50, 8'h70, 8'h30,
      8'ha9, 8'h73, 8'h40, 8'ha5};
   cbu_top i_dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
      .source_mode(source_mode), .pc_in(pc_in), .flags(flags), .acc(acc),
      .data_pointer(data_pointer), .bit_value(bit_value), .pc_valid_q(pc_valid_q),
      .pc_q(pc_q), .branch_taken_q(branch_taken_q), .handled_q(handled_q));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      n_cycles++;
      if (n_cycles == 3000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic run(input logic [7:0] op, input logic esc, input logic sm,
      input logic [3:0] fl, input logic [7:0] rel, input logic [7:0] sub);
      logic ok;
      logic tk;
      logic bt;
      bt = (op == 8'h30) || (op == 8'ha9);
      instr_valid = 1'b1;
      instr = '{op, (op == 8'ha9) ? sub : (op == 8'h30 ? 8'h21 : rel),
         (op == 8'h30) ? rel : ~rel, (op == 8'ha9) ? rel : ~rel, esc};
      source_mode = sm;
      flags = cbu_pkg::cbu_flags_t'(fl);
      acc = fl[0] ? 8'h80 : 8'h00;
      bit_value = fl[1];
      pc_in = {8'hff, fl, 4'h0};
      case (op)
         8'h38, 8'h28, 8'h78, 8'h18, 8'h58: ok = (esc == !sm);
         8'ha9: ok = (esc == !sm) && (sub[7:4] == 4'h3);
         8'h50, 8'h70, 8'h30, 8'h73: ok = !esc;
         default: ok = 1'b0;
      endcase
      case (op)
         8'h38: tk = !fl[2] && !fl[3];
         8'h28: tk = fl[2] || fl[3];
         8'h78: tk = !fl[2];
         8'h18: tk = !fl[2] && (fl[1] == fl[0]);
         8'h58: tk = fl[1] == fl[0];
         8'h50: tk = !fl[3];
         8'h70: tk = acc != 8'h00;
         8'h73: tk = 1'b1;
         default: tk = !bit_value;
      endcase
      last_pc = !ok ? pc_in : (op == 8'h73) ? data_pointer + {8'h00, acc} :
         pc_in + (bt ? 16'h0003 : 16'h0002) + (tk ? {{8{rel[7]}}, rel} : 16'h0000);
      @(posedge clk);
      #1;
      `CHK("pc_valid_q", 1'b1, pc_valid_q)
      `CHK("handled_q", ok, handled_q)
      `CHK("branch_taken_q", ok && tk, branch_taken_q)
      `CHK("pc_q", last_pc, pc_q)
   endtask : run
   initial begin
      n_fail = 0;
      n_tests = 0;
      n_cycles = 0;
      rst_b = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      source_mode = 1'b0;
      pc_in = 16'h0000;
      flags = '0;
      acc = 8'h00;
      data_pointer = 16'hff90;
      bit_value = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      for (int o = 0; o < 12; o++) begin
         for (int m = 0; m < 4; m++) begin
            for (int f = 0; f < 16; f++) begin
               run(ops[o], m[0], m[1], f[3:0], f[0] ? 8'h80 : 8'h7f,
                  (f == 5) ? 8'h21 : 8'h35);
            end
         end
      end
      $display("Test sweep done");
      instr_valid = 1'b0;
      repeat (3) begin
         @(posedge clk);
         #1;
         `CHK("idle pc_valid_q", 1'b0, pc_valid_q)
         `CHK("idle pc_q", last_pc, pc_q)
      end
      $display("Test idle done");
      rst_b = 1'b0;
      #1;
      `CHK("reset pc_valid_q", 1'b0, pc_valid_q)
      `CHK("reset pc_q", 16'h0000, pc_q)
      @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      run(8'h73, 1'b0, 1'b1, 4'h1, 8'h00, 8'h00);
      $display("Test reset done");
      stop_test();
   end
endmodule : test_conditional_branch_unit

/* hdl/cbu_cond.sv */
// Condition evaluator for the branch unit.
`timescale 1ns/1ps
module cbu_cond (
   // Decoded instruction kind.
   input wire logic [7:0] op,
   // Operands.
   input wire cbu_pkg::cbu_flags_t flags,
   input wire logic [7:0] acc,
   input wire logic bit_value,
   // Result.
   output logic taken
);
   always_comb begin
      taken = 1'b0;
      case (op)
         cbu_pkg::OP_UGT: taken = !flags.zero && !flags.carry_flag;
         cbu_pkg::OP_ULE: taken = flags.zero || flags.carry_flag;
         cbu_pkg::OP_NE: taken = !flags.zero;
         cbu_pkg::OP_CARRY_CLR: taken = !flags.carry_flag;
         cbu_pkg::OP_ACC_NZ: taken = |acc;
         cbu_pkg::OP_SGT: taken = !flags.zero && (flags.negative == flags.overflow_flag);
         cbu_pkg::OP_SGE: taken = flags.negative == flags.overflow_flag;
         cbu_pkg::OP_BIT_CLR: taken = !bit_value;
         default: taken = 1'b0;
      endcase
   end
endmodule : cbu_cond

/* hdl/cbu_pkg.sv */
// Constants and types for the conditional branch unit.
// Functional notes
// - Unsigned greater jumps when zero and carry clear.
// - Unsigned less-equal jumps when zero or carry set.
// - Two-byte jump: advance two, then add displacement.
// - Bit jump: displacement from b2 (short) or b3 (extended), after advance.
// - New jumps need escape prefix in binary mode.
// - Indirect jump loads accumulator plus data pointer.
// - Indirect jump is one byte, never prefixed.
// - Short bit-clear jump advances three, branches on zero.
// - Extended bit-clear jump needs escape in binary mode.
// - Carry-clear jump advances two, branches on carry zero.
// - Not-equal jump branches when zero flag clear.
// - Accumulator-nonzero jump branches on any set bit.
// - Signed greater: zero clear and negative equals overflow.
// - Signed greater-equal: negative equals overflow.
package cbu_pkg;
   localparam logic [7:0] OP_ESCAPE = 8'ha5;
   localparam logic [7:0] OP_UGT = 8'h38;
   localparam logic [7:0] OP_ULE = 8'h28;
   localparam logic [7:0] OP_NE = 8'h78;
   localparam logic [7:0] OP_SGT = 8'h18;
   localparam logic [7:0] OP_SGE = 8'h58;
   localparam logic [7:0] OP_CARRY_CLR = 8'h50;
   localparam logic [7:0] OP_ACC_NZ = 8'h70;
   localparam logic [7:0] OP_BIT_CLR = 8'h30;
   localparam logic [7:0] OP_BIT_EXT = 8'ha9;
   localparam logic [3:0] EXT_BIT_CLR_HI = 4'h3;
   localparam logic [7:0] OP_INDIRECT = 8'h73;
   localparam logic [15:0] LEN_TWO = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;
   localparam logic [15:0] LEN_ONE = 16'h0001;
   localparam logic [15:0] PC_RESET = 16'h0000;
   typedef struct packed {
      logic carry_flag;
      logic zero;
      logic negative;
      logic overflow_flag;
   } cbu_flags_t;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic escaped;
   } cbu_instr_t;
endpackage : cbu_pkg

/* hdl/cbu_top.sv */
// Conditional branch unit: decodes jumps and computes the next program counter.
`timescale 1ns/1ps
module cbu_top (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Instruction in.
   input wire logic instr_valid,
   input wire cbu_pkg::cbu_instr_t instr,
   input wire logic source_mode,
   input wire logic [15:0] pc_in,
   // Operands.
   input wire cbu_pkg::cbu_flags_t flags,
   input wire logic [7:0] acc,
   input wire logic [15:0] data_pointer,
   input wire logic bit_value,
   // Results.
   output logic pc_valid_q,
   output logic [15:0] pc_q,
   output logic branch_taken_q,
   output logic handled_q
);
   function automatic logic [15:0] sext(input logic [7:0] d);
      sext = {{8{d[7]}}, d};
   endfunction : sext

   function automatic logic [15:0] advance(input logic [15:0] pc, input logic [15:0] n);
      advance = pc + n;
   endfunction : advance

   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   logic [7:0] cond_op;
   logic is_new;
   logic legal;
   logic cond_taken;
   logic [15:0] len;
   logic [7:0] rel;
   logic pc_valid_d;
   logic [15:0] pc_d;
   logic branch_taken_d;
   logic handled_d;

   cbu_cond u_cond (
      .op(cond_op),
      .flags(flags),
      .acc(acc),
      .bit_value(bit_value),
      .taken(cond_taken)
   );

   always_comb begin
      cond_op = instr.op;
      is_new = 1'b0;
      legal = 1'b0;
      len = cbu_pkg::LEN_TWO;
      rel = instr.b1;
      case (instr.op)
         cbu_pkg::OP_UGT, cbu_pkg::OP_ULE, cbu_pkg::OP_NE,
         cbu_pkg::OP_SGT, cbu_pkg::OP_SGE: begin
            is_new = 1'b1;
            legal = 1'b1;
         end
         cbu_pkg::OP_CARRY_CLR, cbu_pkg::OP_ACC_NZ: begin
            legal = 1'b1;
         end
         cbu_pkg::OP_BIT_CLR: begin
            legal = 1'b1;
            len = cbu_pkg::LEN_THREE;
            rel = instr.b2;
         end
         cbu_pkg::OP_BIT_EXT: begin
            is_new = 1'b1;
            legal = instr.b1[7:4] == cbu_pkg::EXT_BIT_CLR_HI;
            cond_op = cbu_pkg::OP_BIT_CLR;
            len = cbu_pkg::LEN_THREE;
            rel = instr.b3;
         end
         cbu_pkg::OP_INDIRECT: begin
            legal = !instr.escaped;
            len = cbu_pkg::LEN_ONE;
         end
         default: legal = 1'b0;
      endcase
      if (is_new && (instr.escaped == source_mode)) begin
         legal = 1'b0;
      end
      if (!is_new && instr.escaped && (instr.op != cbu_pkg::OP_INDIRECT)) begin
         legal = 1'b0;
      end
      pc_valid_d = 1'b0;
      pc_d = pc_q;
      branch_taken_d = 1'b0;
      handled_d = 1'b0;
      if (instr_valid) begin
         pc_valid_d = 1'b1;
         handled_d = legal;
         if (!legal) begin
            pc_d = pc_in;
         end else if (instr.op == cbu_pkg::OP_INDIRECT) begin
            pc_d = data_pointer + {8'h00, acc};
            branch_taken_d = 1'b1;
         end else if (cond_taken) begin
            pc_d = advance(pc_in, len) + sext(rel);
            branch_taken_d = 1'b1;
         end else begin
            pc_d = advance(pc_in, len);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         pc_valid_q <= 1'b0;
         pc_q <= cbu_pkg::PC_RESET;
         branch_taken_q <= 1'b0;
         handled_q <= 1'b0;
      end else begin
         pc_valid_q <= pc_valid_d;
         pc_q <= pc_d;
         branch_taken_q <= branch_taken_d;
         handled_q <= handled_d;
      end
   end

   // The first term qualifies a request as a new-form jump with the right prefix for the mode.
   // The second term marks an old form that came without any prefix.
   logic new_ok;
   logic old_ok;
   assign new_ok = instr_valid && (instr.escaped != source_mode);
   assign old_ok = instr_valid && !instr.escaped;

   ugt_rule_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_UGT
      |=> branch_taken_q == (!$past(flags.zero) && !$past(flags.carry_flag)))
      else $error("unsigned greater jump wrong");

   ule_rule_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_ULE
      |=> branch_taken_q == ($past(flags.zero) || $past(flags.carry_flag)))
      else $error("unsigned less-equal jump wrong");

   rel_add_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_NE && !flags.zero
      |=> pc_q == $past(pc_in) + cbu_pkg::LEN_TWO + {{8{$past(instr.b1[7])}}, $past(instr.b1)})
      else $error("relative target wrong");

   nt_advance_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_ULE && !flags.zero && !flags.carry_flag
      |=> !branch_taken_q && pc_q == $past(pc_in) + cbu_pkg::LEN_TWO)
      else $error("fall-through address wrong");

   esc_need_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.op == cbu_pkg::OP_SGE && instr.escaped == source_mode
      |=> !handled_q && !branch_taken_q && pc_q == $past(pc_in))
      else $error("prefix mode wrong");

   indir_sum_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.op == cbu_pkg::OP_INDIRECT && !instr.escaped
      |=> branch_taken_q && pc_q == $past(data_pointer) + {8'h00, $past(acc)})
      else $error("indirect jump wrong");

   indir_esc_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.op == cbu_pkg::OP_INDIRECT && instr.escaped
      |=> !handled_q && !branch_taken_q)
      else $error("prefixed indirect jump accepted");

   bit_short_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      old_ok && instr.op == cbu_pkg::OP_BIT_CLR && bit_value
      |=> !branch_taken_q && pc_q == $past(pc_in) + cbu_pkg::LEN_THREE)
      else $error("short bit jump wrong");

   bit_target_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      old_ok && instr.op == cbu_pkg::OP_BIT_CLR && !bit_value
      |=> branch_taken_q && pc_q ==
         $past(pc_in) + cbu_pkg::LEN_THREE + {{8{$past(instr.b2[7])}}, $past(instr.b2)})
      else $error("short bit target wrong");

   ext_need_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.op == cbu_pkg::OP_BIT_EXT && instr.escaped == source_mode
      |=> !handled_q && !branch_taken_q)
      else $error("extended bit prefix wrong");

   ext_target_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_BIT_EXT && !bit_value &&
      instr.b1[7:4] == cbu_pkg::EXT_BIT_CLR_HI
      |=> branch_taken_q && pc_q ==
         $past(pc_in) + cbu_pkg::LEN_THREE + {{8{$past(instr.b3[7])}}, $past(instr.b3)})
      else $error("extended bit target wrong");

   ext_form_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_BIT_EXT && instr.b1[7:4] != cbu_pkg::EXT_BIT_CLR_HI
      |=> !handled_q && !branch_taken_q)
      else $error("extended bit form accepted");

   carry_clr_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      old_ok && instr.op == cbu_pkg::OP_CARRY_CLR
      |=> branch_taken_q == !$past(flags.carry_flag))
      else $error("carry clear jump wrong");

   carry_len_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      old_ok && instr.op == cbu_pkg::OP_CARRY_CLR && flags.carry_flag
      |=> pc_q == $past(pc_in) + cbu_pkg::LEN_TWO)
      else $error("carry clear advance wrong");

   ne_rule_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_NE
      |=> branch_taken_q == !$past(flags.zero))
      else $error("not-equal jump wrong");

   acc_nz_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      old_ok && instr.op == cbu_pkg::OP_ACC_NZ
      |=> branch_taken_q == ($past(acc) != 8'h00))
      else $error("accumulator jump wrong");

   acc_zero_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      old_ok && instr.op == cbu_pkg::OP_ACC_NZ && acc == 8'h00
      |=> pc_q == $past(pc_in) + cbu_pkg::LEN_TWO)
      else $error("accumulator advance wrong");

   sgt_rule_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_SGT
      |=> branch_taken_q ==
         (!$past(flags.zero) && ($past(flags.negative) == $past(flags.overflow_flag))))
      else $error("signed greater jump wrong");

   sge_rule_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_SGE
      |=> branch_taken_q == ($past(flags.negative) == $past(flags.overflow_flag)))
      else $error("signed greater-equal jump wrong");

   back_jump_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      new_ok && instr.op == cbu_pkg::OP_NE && !flags.zero && instr.b1 == 8'h80
      |=> pc_q == $past(pc_in) + cbu_pkg::LEN_TWO - 16'h0080)
      else $error("backward jump wrong");

   old_prefix_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.escaped && instr.op == cbu_pkg::OP_ACC_NZ
      |=> !handled_q && pc_q == $past(pc_in))
      else $error("prefixed old jump accepted");

   idle_valid_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      !instr_valid
      |=> !pc_valid_q && !branch_taken_q && !handled_q)
      else $error("result without instruction");

   hold_pc_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      !instr_valid
      |=> pc_q == $past(pc_q))
      else $error("address moved while idle");

   valid_pulse_a: assert property (
      @(posedge clk) disable iff (!rst_s2_q)
      instr_valid
      |=> pc_valid_q)
      else $error("result missing");

   // These covers mark the main scenarios.
   ext_bit_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.op == cbu_pkg::OP_BIT_EXT ##1 branch_taken_q);

   back_jump_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.b1[7] && instr.op == cbu_pkg::OP_NE ##1 branch_taken_q);

   indirect_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
      instr_valid && instr.op == cbu_pkg::OP_INDIRECT ##1 handled_q);

   ugt_source_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
      new_ok && source_mode && instr.op == cbu_pkg::OP_UGT ##1 branch_taken_q);

   refused_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
      instr_valid ##1 pc_valid_q && !handled_q);
endmodule : cbu_top
